// ==== src/ucg_pkg.sv ====
package ucg_pkg;
    // Register byte addresses
    localparam logic [11:0] UCG_ADDR_CTRL = 12'h000;
    localparam logic [11:0] UCG_ADDR_DIV_LOW = 12'h004;
    localparam logic [11:0] UCG_ADDR_DIV_HIGH = 12'h008;
    localparam logic [11:0] UCG_ADDR_STATUS = 12'h00C;
    // Control register fields
    localparam int UCG_CTRL_SYNC_BIT = 0;
    localparam int UCG_CTRL_DSPEED_BIT = 1;
    localparam int UCG_CTRL_DIR_BIT = 2;
    localparam int UCG_CTRL_POL_BIT = 3;
    // Divisor layout
    localparam int UCG_DIV_W = 12;
    localparam int UCG_DIV_LOW_W = 8;
    localparam int UCG_DIV_HIGH_W = 4;
    localparam logic [11:0] UCG_DIV_RESET = 12'h000;
    // Prescale ratios after the generator, minus one
    localparam logic [3:0] UCG_RATIO_NORMAL = 4'hF;
    localparam logic [3:0] UCG_RATIO_DOUBLE = 4'h7;
    localparam logic [3:0] UCG_RATIO_SYNC = 4'h1;
    // Clock source modes
    typedef enum logic [1:0] {
        ucg_async_normal,
        ucg_async_double,
        ucg_sync_master,
        ucg_sync_slave
    } ucg_mode_e;
endpackage

// ==== src/ucg_edge_if.sv ====
`timescale 1ns/1ps
// Edge events from the external transfer clock path
interface ucg_edge_if;
    logic rise;
    logic fall;
    logic level;
    modport src (output rise, output fall, output level);
    modport dst (input rise, input fall, input level);
endinterface

// ==== src/ucg_ext_sync.sv ====
`timescale 1ns/1ps
// Synchroniser and edge detector for the external transfer clock
module ucg_ext_sync
    import ucg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic xfer_clk_pin_i,
    ucg_edge_if.src edges
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Two-stage synchroniser, then one stage for edge history
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= xfer_clk_pin_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edge pulses only while slave mode uses the pin
    assign edges.rise = enable && sync_r && !prev_r;
    assign edges.fall = enable && !sync_r && prev_r;
    assign edges.level = sync_r;
endmodule

// ==== src/ucg_clock_gen.sv ====
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Four clock modes; a mode-select bit picks async or sync family.
// - A double-speed bit selects double-speed operation, async only.
// - In sync mode the pin direction picks master (output) or slave (input).
// - The transfer-clock pin is used only in synchronous modes.
// - The baud generator serves both async modes and sync master.
// - Down-counter reloads at zero and on every low divisor byte write.
// - One generator pulse per zero count: rate is clock over divisor plus one.
// - Divisor is twelve bits, high and low parts, 0 to 4095.
// - Transmit clock is generator output divided by 2, 8 or 16 per mode.
// - Receiver gets generator pulses and a 2, 8 or 16 state recovery count.
// - Normal async bit rate is clock over sixteen times divisor plus one.
// - Double-speed bit rate is clock over eight times divisor plus one.
// - Double-speed bit is ignored in sync modes; software keeps it clear.
// - Double speed drops transmit and receive ratio from 16 to 8.
// - External pin clock serves synchronous slave mode only.
// - External clock passes synchroniser and edge detector, two clocks delay.
// - Sync data sampled on edge opposite the change edge, set by polarity.
module ucg_clock_gen
    import ucg_pkg::*;
#(
    parameter int DIV_W = UCG_DIV_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic xfer_clk_pin_i,
    output logic xfer_clk_pin_o,
    output logic xfer_clk_pin_oe,
    output logic tx_clk_en,
    output logic rx_clk_en,
    output logic [3:0] rx_sample_phase,
    output logic sync_change_en,
    output logic sync_sample_en,
    output logic [1:0] clk_mode
);
    initial begin
        if (DIV_W != UCG_DIV_LOW_W + UCG_DIV_HIGH_W) begin
            $error("ucg_clock_gen: DIV_W must equal the low plus high divisor widths");
        end
    end

    logic sync_mode_select_r;
    logic double_speed_bit_r;
    logic xfer_clk_pin_direction_r;
    logic sync_clock_polarity_r;
    logic [UCG_DIV_LOW_W-1:0] baud_divisor_low_r;
    logic [UCG_DIV_HIGH_W-1:0] baud_divisor_high_r;
    logic [DIV_W-1:0] count_r;
    logic [3:0] tx_div_r;
    logic [3:0] rx_state_r;
    logic xck_out_r;
    logic tx_clk_en_r;
    logic rx_clk_en_r;
    logic change_en_r;
    logic sample_en_r;
    ucg_mode_e mode;
    logic wr_en;
    logic low_wr;
    logic gen_tick;
    logic gen_on;
    logic slave_on;
    logic [3:0] ratio;
    logic [DIV_W-1:0] div_full;
    logic [31:0] rd_mux;
    ucg_edge_if edges ();

    // APB access decode; every transfer completes in its first access cycle
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign low_wr = wr_en && (paddr == UCG_ADDR_DIV_LOW);

    // Mode decode from the control bits
    always_comb begin
        if (!sync_mode_select_r) begin
            mode = double_speed_bit_r ? ucg_async_double : ucg_async_normal;
        end else if (xfer_clk_pin_direction_r) begin
            mode = ucg_sync_master;
        end else begin
            mode = ucg_sync_slave;
        end
    end

    // Generator runs for async and sync master only
    assign gen_on = (mode != ucg_sync_slave);
    assign slave_on = (mode == ucg_sync_slave);
    assign div_full = {baud_divisor_high_r, baud_divisor_low_r};

    // Ratio of bit clock to generator pulse, per mode
    function automatic logic [3:0] mode_ratio(input ucg_mode_e m);
        unique case (m)
            ucg_async_normal: mode_ratio = UCG_RATIO_NORMAL;
            ucg_async_double: mode_ratio = UCG_RATIO_DOUBLE;
            ucg_sync_master: mode_ratio = UCG_RATIO_SYNC;
            ucg_sync_slave: mode_ratio = UCG_RATIO_SYNC;
        endcase
    endfunction
    assign ratio = mode_ratio(mode);

    // Control register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_mode_select_r <= 1'b0;
            double_speed_bit_r <= 1'b0;
            xfer_clk_pin_direction_r <= 1'b0;
            sync_clock_polarity_r <= 1'b0;
        end else if (wr_en && paddr == UCG_ADDR_CTRL) begin
            sync_mode_select_r <= pwdata[UCG_CTRL_SYNC_BIT];
            double_speed_bit_r <= pwdata[UCG_CTRL_DSPEED_BIT];
            xfer_clk_pin_direction_r <= pwdata[UCG_CTRL_DIR_BIT];
            sync_clock_polarity_r <= pwdata[UCG_CTRL_POL_BIT];
        end
    end

    // Divisor register writes; high part is only staged here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            baud_divisor_low_r <= UCG_DIV_RESET[UCG_DIV_LOW_W-1:0];
            baud_divisor_high_r <= UCG_DIV_RESET[DIV_W-1:UCG_DIV_LOW_W];
        end else begin
            if (low_wr) begin
                baud_divisor_low_r <= pwdata[UCG_DIV_LOW_W-1:0];
            end
            if (wr_en && paddr == UCG_ADDR_DIV_HIGH) begin
                baud_divisor_high_r <= pwdata[UCG_DIV_HIGH_W-1:0];
            end
        end
    end

    // Baud down-counter, reloads at zero or on low byte write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= UCG_DIV_RESET;
        end else if (low_wr) begin
            count_r <= {baud_divisor_high_r, pwdata[UCG_DIV_LOW_W-1:0]};
        end else if (count_r == '0) begin
            count_r <= div_full;
        end else begin
            count_r <= count_r - 1'b1;
        end
    end

    // One generator pulse per zero count
    assign gen_tick = gen_on && !low_wr && (count_r == '0);

    // Transmit prescaler: divide generator pulses by 2, 8 or 16
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_div_r <= 4'h0;
            tx_clk_en_r <= 1'b0;
            xck_out_r <= 1'b0;
        end else begin
            tx_clk_en_r <= 1'b0;
            if (!gen_on) begin
                tx_div_r <= 4'h0;
                xck_out_r <= 1'b0;
            end else if (gen_tick) begin
                if (tx_div_r >= ratio) begin
                    tx_div_r <= 4'h0;
                    tx_clk_en_r <= 1'b1;
                end else begin
                    tx_div_r <= tx_div_r + 4'h1;
                end
                // Master pin clock toggles each generator pulse: rate over two
                xck_out_r <= (mode == ucg_sync_master) ? !xck_out_r : 1'b0;
            end
        end
    end

    // Receiver recovery state counter and base clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_r <= 4'h0;
            rx_clk_en_r <= 1'b0;
        end else begin
            rx_clk_en_r <= gen_on ? gen_tick : edges.rise || edges.fall;
            if (gen_tick || (slave_on && (edges.rise || edges.fall))) begin
                rx_state_r <= (rx_state_r >= ratio) ? 4'h0 : rx_state_r + 4'h1;
            end else if (rx_state_r > ratio) begin
                rx_state_r <= 4'h0;
            end
        end
    end

    // Sync change and sample strobes on opposite pin edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            change_en_r <= 1'b0;
            sample_en_r <= 1'b0;
        end else if (!sync_mode_select_r) begin
            change_en_r <= 1'b0;
            sample_en_r <= 1'b0;
        end else if (slave_on) begin
            change_en_r <= sync_clock_polarity_r ? edges.fall : edges.rise;
            sample_en_r <= sync_clock_polarity_r ? edges.rise : edges.fall;
        end else begin
            // Master: next pin level is the toggled value
            change_en_r <= gen_tick && (sync_clock_polarity_r == xck_out_r);
            sample_en_r <= gen_tick && (sync_clock_polarity_r != xck_out_r);
        end
    end

    // External pin path, active only in slave mode
    ucg_ext_sync u_ext_sync (
        .clk(clk),
        .reset_n(reset_n),
        .enable(slave_on),
        .xfer_clk_pin_i(xfer_clk_pin_i),
        .edges(edges)
    );

    // Pin drive only in sync master
    assign xfer_clk_pin_o = xck_out_r;
    assign xfer_clk_pin_oe = (mode == ucg_sync_master);

    // Read data mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            UCG_ADDR_CTRL: begin
                rd_mux[UCG_CTRL_SYNC_BIT] = sync_mode_select_r;
                rd_mux[UCG_CTRL_DSPEED_BIT] = double_speed_bit_r;
                rd_mux[UCG_CTRL_DIR_BIT] = xfer_clk_pin_direction_r;
                rd_mux[UCG_CTRL_POL_BIT] = sync_clock_polarity_r;
            end
            UCG_ADDR_DIV_LOW: rd_mux[UCG_DIV_LOW_W-1:0] = baud_divisor_low_r;
            UCG_ADDR_DIV_HIGH: rd_mux[UCG_DIV_HIGH_W-1:0] = baud_divisor_high_r;
            UCG_ADDR_STATUS: begin
                rd_mux[DIV_W-1:0] = count_r;
                rd_mux[DIV_W+1:DIV_W] = mode;
                rd_mux[DIV_W+2] = edges.level;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Clock enable outputs
    assign tx_clk_en = tx_clk_en_r;
    assign rx_clk_en = rx_clk_en_r;
    assign rx_sample_phase = rx_state_r;
    assign sync_change_en = change_en_r;
    assign sync_sample_en = sample_en_r;
    assign clk_mode = mode;
endmodule

// ==== verif/ucg_clock_gen_sva.sv ====
`timescale 1ns/1ps
module ucg_chk
    import ucg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic xfer_clk_pin_i,
    input wire logic xfer_clk_pin_oe,
    input wire logic tx_clk_en,
    input wire logic rx_clk_en,
    input wire logic sync_change_en,
    input wire logic sync_sample_en,
    input wire logic [1:0] clk_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Fifteen quiet cycles after a normal-rate transmit tick
    sequence s_quiet_normal;
        (!tx_clk_en || clk_mode != ucg_async_normal) [*8] ##1
        (!tx_clk_en || clk_mode != ucg_async_normal) [*7];
    endsequence
    // Seven quiet cycles after a double-rate transmit tick
    sequence s_quiet_double;
        (!tx_clk_en || clk_mode != ucg_async_double) [*7];
    endsequence
    a_oe_master_only: assert property (clk_mode == ucg_sync_master && $stable(clk_mode) |-> xfer_clk_pin_oe) else $error("pin not driven in master");
    a_oe_off_otherwise: assert property (clk_mode != ucg_sync_master && $stable(clk_mode) |-> !xfer_clk_pin_oe) else $error("pin driven outside master");
    a_apb_zero_wait: assert property (pready && !pslverr) else $error("bus answer wrong");
    a_sync_off_async: assert property (!clk_mode[1] && !$past(clk_mode[1]) |-> !sync_change_en && !sync_sample_en) else $error("sync edge in async mode");
    a_sync_edges_apart: assert property (!(sync_change_en && sync_sample_en)) else $error("change and sample together");
    a_tx_normal_gap: assert property (tx_clk_en && clk_mode == ucg_async_normal |=> s_quiet_normal) else $error("normal tick too soon");
    a_tx_double_gap: assert property (tx_clk_en && clk_mode == ucg_async_double |=> s_quiet_double) else $error("double tick too soon");
    a_slave_edge_delay: assert property (clk_mode == ucg_sync_slave && $stable(clk_mode) && $changed(xfer_clk_pin_i) |-> ##[1:4] rx_clk_en) else $error("pin edge lost");
    a_tx_from_gen: assert property (tx_clk_en && clk_mode != ucg_sync_slave |-> rx_clk_en || $past(rx_clk_en) || $past(rx_clk_en, 2)) else $error("tick without generator");
endmodule

// ==== verif/ucg_remote_dev.sv ====
`timescale 1ns/1ps
module ucg_remote_dev (
    input wire logic clk,
    output logic pin_drv
);
    // Clock stands low between bursts
    initial pin_drv = 1'b0;
    // Burst of clock edges, half period of at least three system clocks
    task automatic run(input int edges, input int half);
        for (int e = 0; e < edges; e++) begin
            repeat (half) @(posedge clk);
            pin_drv <= ~pin_drv;
        end
    endtask
endmodule

// ==== verif/test_ucg_clock_gen.sv ====
`timescale 1ns/1ps
module test_ucg_clock_gen
    import ucg_pkg::*;
;
    logic clk, reset_n, psel, penable, pwrite, pin_drv, pin_wire, pin_o, pin_oe;
    logic pready, pslverr, tx, rx, chg, smp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] phase;
    logic [1:0] mode;
    int n_mismatch = 0;
    int tests_run = 0;
    int p, cnt, c2;
    // Control word and transmit ratio per mode case; divisor table
    logic [31:0] ctl [4] = '{32'h0, 32'h2, 32'h5, 32'h7};
    int mul [4] = '{16, 8, 2, 2};
    int dh [4] = '{0, 1, 15, 3};
    int dl [4] = '{0, 2, 255, 255};
    // Pin wire: master drive when enabled, else the remote device
    assign pin_wire = pin_oe ? pin_o : pin_drv;
    ucg_clock_gen ucg_clock_gen_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xfer_clk_pin_i(pin_wire), .xfer_clk_pin_o(pin_o),
        .xfer_clk_pin_oe(pin_oe), .tx_clk_en(tx), .rx_clk_en(rx), .rx_sample_phase(phase),
        .sync_change_en(chg), .sync_sample_en(smp), .clk_mode(mode));
    ucg_remote_dev ucg_remote_dev_i (.clk(clk), .pin_drv(pin_drv));
    // Clock source
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic conclude;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        if (n >= 50) begin
            n_mismatch++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle so the next call never reassigns psel in this time step
        @(posedge clk);
    endtask
    // Cycles between two pulses: 0 transmit tick, 1 receive tick, 2 pin toggle
    task automatic period(input int sel, output int p);
        int n, t0, t1, hits;
        logic prev;
        n = 0;
        hits = 0;
        t0 = 0;
        t1 = 0;
        prev = pin_o;
        while (hits < 3) begin
            @(posedge clk);
            #1;
            n++;
            if ((sel == 0 && tx === 1'b1) || (sel == 1 && rx === 1'b1)
                || (sel == 2 && pin_o !== prev)) begin
                hits++;
                t0 = t1;
                t1 = n;
            end
            prev = pin_o;
            if (n > 20000) begin
                n_mismatch++;
                conclude();
            end
        end
        p = t1 - t0;
        @(posedge clk);
    endtask
    // Unit is clocked from reset, nothing to power up first
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, UCG_ADDR_STATUS, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        apb(1'b0, 12'h010, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, UCG_ADDR_DIV_LOW, 32'h3);
        // Last case sets double speed in sync mode to show it is ignored
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, UCG_ADDR_CTRL, ctl[i]);
            period(0, p);
            chk(p, mul[i] * 4);
            period(1, p);
            chk(p, 4);
            // Highest recovery state seen equals the per-mode ratio minus one
            cnt = 0;
            repeat (mul[i] * 8) begin
                @(posedge clk);
                #1;
                if (phase > cnt) cnt = phase;
            end
            @(posedge clk);
            chk(cnt, mul[i] - 1);
            chk({30'h0, mode}, (i < 3) ? i : 2);
            chk({31'h0, pin_oe}, i >= 2);
            if (i >= 2) begin
                period(2, p);
                chk(p, 4);
            end
        end
        apb(1'b1, UCG_ADDR_CTRL, 32'h1);
        repeat (10) @(posedge clk);
        cnt = 0;
        c2 = 0;
        fork
            ucg_remote_dev_i.run(8, 3);
            repeat (40) begin
                @(posedge clk);
                #1;
                cnt += (rx === 1'b1);
                c2 += (chg === 1'b1);
            end
        join
        chk(cnt, 8);
        chk(c2, 4);
        chk({31'h0, pin_oe}, 0);
        apb(1'b0, UCG_ADDR_STATUS, 32'h0);
        chk({30'h0, r[13:12]}, 3);
        apb(1'b1, UCG_ADDR_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, UCG_ADDR_DIV_HIGH, dh[i]);
            apb(1'b1, UCG_ADDR_DIV_LOW, dl[i]);
            period(1, p);
            chk(p, dh[i] * 256 + dl[i] + 1);
            if (i < 2) begin
                period(0, p);
                chk(p, 16 * (dh[i] * 256 + dl[i] + 1));
            end
        end
        repeat (100) @(posedge clk);
        apb(1'b1, UCG_ADDR_DIV_LOW, 32'hFF);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (rx !== 1'b1 && cnt < 2000);
        chk({31'h0, cnt >= 1000}, 1);
        conclude();
    end
endmodule
bind ucg_clock_gen ucg_chk ucg_chk_i (.clk(clk), .reset_n(reset_n), .pready(pready),
    .pslverr(pslverr), .xfer_clk_pin_i(xfer_clk_pin_i), .xfer_clk_pin_oe(xfer_clk_pin_oe),
    .tx_clk_en(tx_clk_en), .rx_clk_en(rx_clk_en), .sync_change_en(sync_change_en),
    .sync_sample_en(sync_sample_en), .clk_mode(clk_mode));
